// File: rtl/flsr_regs.svh
/*
  Constants of the flow sensor identification and readout block: command
  codes, checksum settings, code limits and transfer lengths.
  Assumes it is included once per file by its bare name.
*/
`ifndef FLSR_REGS_SVH
`define FLSR_REGS_SVH

// ----------------------------------------
// Commands, 16 bits each
// ----------------------------------------
`define FLSR_CMD_START_WATER 16'h3608
`define FLSR_CMD_START_IPA 16'h3615
`define FLSR_CMD_STOP 16'h3FF9
`define FLSR_CMD_ID_FIRST 16'h367C
`define FLSR_CMD_ID_SECOND 16'hE102

// ----------------------------------------
// Checksum
// ----------------------------------------
`define FLSR_CRC_POLY 8'h31
`define FLSR_CRC_INIT 8'hFF
`define FLSR_CRC_XOROUT 8'h00

// ----------------------------------------
// Codes and lengths
// ----------------------------------------
`define FLSR_FLOW_MAX 16'sh7EF4
`define FLSR_FLOW_MIN -16'sh7EF4
`define FLSR_ID_WORDS 3'd6
`define FLSR_MEAS_WORDS 3'd3
`define FLSR_IDLE_BYTE 8'hFF
`define FLSR_FIFO_DEPTH 4

`endif

// File: rtl/flsr_pkg.sv
/*
  Types of the flow sensor identification and readout block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package flsr_pkg;

  // ----------------------------------------
  // Bus side states and command modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_WR_BYTE,
    ST_ACK_WR,
    ST_RD_BYTE,
    ST_ACK_RD
  } flsr_state_t;

  typedef enum logic [1:0] {
    MD_IDLE,
    MD_ID_ARM,
    MD_ID_RDY,
    MD_MEAS
  } flsr_mode_t;

  // ----------------------------------------
  // One measurement set from the sensing core
  // ----------------------------------------
  typedef struct packed {
    logic signed [15:0] flow;
    logic signed [15:0] temp;
    logic [15:0] flags;
  } flsr_sample_t;

endpackage

// File: rtl/flsr_fifo.sv
/*
  Small flip-flop FIFO with valid and ready on both sides.
  Assumes one clock and a synchronous active high reset.
*/
`timescale 1ns/1ps
module flsr_fifo
  import flsr_pkg::*;
#(
  parameter int WIDTH = 48,
  parameter int DEPTH = 4
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic ready_r;
  logic empty_r;
  logic push;
  logic pop;
  logic [AW:0] count_nxt;

  assign push = in_valid && ready_r;
  assign pop = out_ready && !empty_r;
  assign count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign in_ready = ready_r;
  assign out_valid = !empty_r;
  assign out_data = mem_r[rd_ptr_r];

  // ----------------------------------------
  // Pointers and flags
  // ----------------------------------------
  // Ready and empty are kept as flops so the ready seen upstream is clean
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      ready_r <= 1'b1;
      empty_r <= 1'b1;
    end
    else
    begin
      if (push)
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      count_r <= count_nxt;
      ready_r <= (count_nxt != (AW + 1)'(DEPTH));
      empty_r <= (count_nxt == '0);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data;
  end

endmodule // flsr_fifo

// File: rtl/flsr_top.sv
/*
  Serial bus target of a liquid flow sensor: command intake, identification
  readout, measurement readout and per word checksum.
  Assumes the bus pins are open drain and asynchronous to core_clk, which
  must run well above eight times the bus clock rate.
*/
`timescale 1ns/1ps
`include "flsr_regs.svh"

// What this block does
// - After both commands a read returns six words, each with checksum, eighteen bytes.
// - Product number goes first, most significant byte first, checksums at bytes three, six.
// - Then the 64-bit serial number, most significant first, four words with checksums.
// - Low eight bits of the 32-bit identifier are a revision code.
// - Each checksum covers only the two data bytes just before it.
// - Checksum is CRC-8, polynomial 0x31, init 0xFF, unreflected, final XOR 0x00.
// - Flow codes are two's complement, never outside minus 32500 to plus 32500.
// - Sensor drives the data line during read data bytes and its address and write acknowledge bits; host drives otherwise.
// - During continuous measurement only stop is accepted; host stops first. The block still acknowledges other commands there and ignores them.
module flsr_top
  import flsr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h08,
  // Arbitrary value, low byte is the revision code
  parameter logic [31:0] PROD_ID = 32'h0A0B_0C01,
  // Arbitrary value
  parameter logic [63:0] SERIAL_NO = 64'h0123_4567_89AB_CDEF
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic smp_valid,
  input wire flsr_sample_t smp_data,
  output logic smp_ready,
  output logic meas_en,
  output logic med_ipa
);

  // ----------------------------------------
  // Checksum
  // ----------------------------------------
  function automatic logic [7:0] flsr_crc8(input logic [15:0] d);
    logic [7:0] c;
    c = `FLSR_CRC_INIT;
    for (int i = 15; i >= 0; i--)
    begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ `FLSR_CRC_POLY) : {c[6:0], 1'b0};
    end
    return c ^ `FLSR_CRC_XOROUT;
  endfunction

  function automatic logic signed [15:0] flsr_clamp(input logic signed [15:0] f);
    if (f > `FLSR_FLOW_MAX)
      return `FLSR_FLOW_MAX;
    else if (f < `FLSR_FLOW_MIN)
      return `FLSR_FLOW_MIN;
    else
      return f;
  endfunction

  // ----------------------------------------
  // Pin synchronisers and bus conditions
  // ----------------------------------------
  logic scl_s1_r, scl_s2_r, scl_d_r;
  logic sda_s1_r, sda_s2_r, sda_d_r;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      {scl_s1_r, scl_s2_r, scl_d_r} <= 3'b111;
      {sda_s1_r, sda_s2_r, sda_d_r} <= 3'b111;
    end
    else
    begin
      scl_s1_r <= scl_in;
      scl_s2_r <= scl_s1_r;
      scl_d_r <= scl_s2_r;
      sda_s1_r <= sda_in;
      sda_s2_r <= sda_s1_r;
      sda_d_r <= sda_s2_r;
    end
  end

  wire scl_rise = scl_s2_r && !scl_d_r;
  wire scl_fall = !scl_s2_r && scl_d_r;
  wire bus_start = scl_s2_r && scl_d_r && !sda_s2_r && sda_d_r;
  wire bus_stop = scl_s2_r && scl_d_r && sda_s2_r && !sda_d_r;

  // ----------------------------------------
  // Measurement buffer
  // ----------------------------------------
  flsr_state_t st_r;
  flsr_mode_t mode_r;
  flsr_sample_t cur_r;
  logic cur_valid_r;
  logic fifo_valid;
  logic [$bits(flsr_sample_t)-1:0] fifo_data;
  // Drained only while the bus is quiet so a set never changes mid read
  wire fifo_take = (mode_r == MD_MEAS) && !cur_valid_r && (st_r == ST_IDLE);

  flsr_fifo #(
    .WIDTH($bits(flsr_sample_t)),
    .DEPTH(`FLSR_FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(smp_valid),
    .in_data(smp_data),
    .in_ready(smp_ready),
    .out_valid(fifo_valid),
    .out_ready(fifo_take),
    .out_data(fifo_data)
  );

  // ----------------------------------------
  // Transmit byte selection
  // ----------------------------------------
  logic [3:0] bit_cnt_r;
  logic [7:0] rx_r;
  logic rw_r;
  logic [2:0] word_r;
  logic [1:0] pos_r;
  logic first_wr_r;
  logic [7:0] cmd_hi_r;
  logic sda_oe_n_r;
  logic meas_en_r;
  logic med_ipa_r;

  wire in_id = (mode_r == MD_ID_RDY);
  wire [15:0] id_word =
    (word_r == 3'd0) ? PROD_ID[31:16] :
    (word_r == 3'd1) ? PROD_ID[15:0] :
    (word_r == 3'd2) ? SERIAL_NO[63:48] :
    (word_r == 3'd3) ? SERIAL_NO[47:32] :
    (word_r == 3'd4) ? SERIAL_NO[31:16] : SERIAL_NO[15:0];
  wire [15:0] meas_word =
    (word_r == 3'd0) ? cur_r.flow :
    (word_r == 3'd1) ? cur_r.temp : cur_r.flags;
  wire [2:0] word_lim = in_id ? `FLSR_ID_WORDS : `FLSR_MEAS_WORDS;
  wire [15:0] tx_word = in_id ? id_word : meas_word;
  // Past the last word the line is simply released
  wire [7:0] tx_byte =
    (word_r >= word_lim) ? `FLSR_IDLE_BYTE :
    (pos_r == 2'd0) ? tx_word[15:8] :
    (pos_r == 2'd1) ? tx_word[7:0] :
    flsr_crc8(tx_word);
  wire tx_bit = tx_byte[3'd7 - bit_cnt_r[2:0]];
  wire [7:0] rx_byte = {rx_r[6:0], sda_s2_r};
  wire addr_hit = (rx_r[7:1] == DEV_ADDR);
  wire can_read = in_id || ((mode_r == MD_MEAS) && cur_valid_r);
  wire [15:0] cmd_word = {cmd_hi_r, rx_r};

  // ----------------------------------------
  // Bus state machine
  // ----------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      rx_r <= 8'h00;
      rw_r <= 1'b0;
      word_r <= 3'd0;
      pos_r <= 2'd0;
      first_wr_r <= 1'b1;
      cmd_hi_r <= 8'h00;
      sda_oe_n_r <= 1'b1;
    end
    else if (bus_start)
    begin
      st_r <= ST_ADDR;
      bit_cnt_r <= 4'h0;
      sda_oe_n_r <= 1'b1;
    end
    else if (bus_stop)
    begin
      st_r <= ST_IDLE;
      sda_oe_n_r <= 1'b1;
    end
    else
    begin
      case (st_r)
        ST_ADDR, ST_WR_BYTE:
        begin
          if (scl_rise)
          begin
            rx_r <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          else if (scl_fall && bit_cnt_r == 4'h8)
          begin
            if (st_r == ST_WR_BYTE)
            begin
              st_r <= ST_ACK_WR;
              sda_oe_n_r <= 1'b0;
              first_wr_r <= !first_wr_r;
              cmd_hi_r <= rx_r;
            end
            else if (addr_hit && (!rx_r[0] || can_read))
            begin
              st_r <= ST_ACK_ADDR;
              rw_r <= rx_r[0];
              sda_oe_n_r <= 1'b0;
              first_wr_r <= 1'b1;
            end
            else
              st_r <= ST_IDLE;
          end
        end
        ST_ACK_ADDR, ST_ACK_WR:
        begin
          if (scl_fall)
          begin
            bit_cnt_r <= 4'h0;
            if (st_r == ST_ACK_ADDR && rw_r)
            begin
              st_r <= ST_RD_BYTE;
              word_r <= 3'd0;
              pos_r <= 2'd0;
              sda_oe_n_r <= in_id ? PROD_ID[31] : cur_r.flow[15];
            end
            else
            begin
              st_r <= ST_WR_BYTE;
              sda_oe_n_r <= 1'b1;
            end
          end
        end
        ST_RD_BYTE:
        begin
          if (scl_rise)
            bit_cnt_r <= bit_cnt_r + 4'h1;
          else if (scl_fall)
          begin
            if (bit_cnt_r == 4'h8)
            begin
              st_r <= ST_ACK_RD;
              sda_oe_n_r <= 1'b1;
              pos_r <= (pos_r == 2'd2) ? 2'd0 : pos_r + 2'd1;
              if (pos_r == 2'd2 && word_r < word_lim)
                word_r <= word_r + 3'd1;
            end
            else
              sda_oe_n_r <= tx_bit;
          end
        end
        ST_ACK_RD:
        begin
          if (scl_rise && sda_s2_r)
            st_r <= ST_IDLE;
          else if (scl_fall)
          begin
            st_r <= ST_RD_BYTE;
            bit_cnt_r <= 4'h0;
            sda_oe_n_r <= tx_byte[7];
          end
        end
        default:
          sda_oe_n_r <= 1'b1;
      endcase
    end
  end

  // ----------------------------------------
  // Command handling and measurement set
  // ----------------------------------------
  wire cmd_done = !bus_start && !bus_stop && (st_r == ST_WR_BYTE) && scl_fall &&
    (bit_cnt_r == 4'h8) && !first_wr_r;
  wire rd_taken = !bus_start && !bus_stop && (st_r == ST_ADDR) && scl_fall &&
    (bit_cnt_r == 4'h8) && addr_hit && rx_r[0] && can_read;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      mode_r <= MD_IDLE;
      meas_en_r <= 1'b0;
      med_ipa_r <= 1'b0;
    end
    else if (cmd_done)
    begin
      if (mode_r == MD_MEAS)
      begin
        if (cmd_word == `FLSR_CMD_STOP)
        begin
          mode_r <= MD_IDLE;
          meas_en_r <= 1'b0;
        end
      end
      else if (cmd_word == `FLSR_CMD_ID_FIRST)
        mode_r <= MD_ID_ARM;
      else if (cmd_word == `FLSR_CMD_ID_SECOND)
        mode_r <= (mode_r == MD_ID_ARM) ? MD_ID_RDY : MD_IDLE;
      else if (cmd_word == `FLSR_CMD_START_WATER || cmd_word == `FLSR_CMD_START_IPA)
      begin
        mode_r <= MD_MEAS;
        meas_en_r <= 1'b1;
        med_ipa_r <= (cmd_word == `FLSR_CMD_START_IPA);
      end
      else
        mode_r <= MD_IDLE;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cur_r <= '0;
      cur_valid_r <= 1'b0;
    end
    else if (mode_r != MD_MEAS)
      cur_valid_r <= 1'b0;
    else if (fifo_take && fifo_valid)
    begin
      // Clamped on intake so every read sees a legal code
      cur_r <= {flsr_clamp(fifo_data[47:32]), fifo_data[31:0]};
      cur_valid_r <= 1'b1;
    end
    else if (rd_taken)
      cur_valid_r <= 1'b0;
  end

  // Line is open drain: the data flop only ever pulls low
  always_ff @(posedge core_clk)
  begin
    if (rst)
      sda_out <= 1'b0;
    else
      sda_out <= 1'b0;
  end

  assign sda_oe_n = sda_oe_n_r;
  assign meas_en = meas_en_r;
  assign med_ipa = med_ipa_r;

endmodule // flsr_top

// File: sim/flsr_host.sv
/*
  Bus master model of the host: start, stop, byte, command and read tasks.
  Assumes a 40 MHz core_clk and a pull-up on the shared data wire.
*/
`timescale 1ns/1ps
module flsr_host (
  input wire logic core_clk,
  input wire logic sda_w,
  output logic scl,
  output logic sda_m
);
  // ----------------------------------------
  // Bus phases of 10 core clocks
  // ----------------------------------------
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Data moves 2 clocks after the clock fall, never in the same step
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    hw(10);
    scl = 1'b1;
    hw(5);
    r = sda_w;
    hw(5);
    scl = 1'b0;
    hw(2);
  endtask
  task automatic start();
    sda_m = 1'b1;
    hw(10);
    scl = 1'b1;
    hw(10);
    sda_m = 1'b0;
    hw(10);
    scl = 1'b0;
    hw(2);
  endtask
  task automatic stop();
    sda_m = 1'b0;
    hw(10);
    scl = 1'b1;
    hw(10);
    sda_m = 1'b1;
    hw(10);
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic get(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask
  task automatic cmd(input logic [6:0] a, input logic [15:0] c, output logic ack);
    logic k0, k1, k2;
    start();
    put({a, 1'b0}, k0);
    put(c[15:8], k1);
    put(c[7:0], k2);
    stop();
    ack = k0 & k1 & k2;
  endtask
  task automatic rd(input logic [6:0] a, input int n, output logic ack,
    output logic [7:0] q [18]);
    start();
    put({a, 1'b1}, ack);
    for (int i = 0; i < n && ack; i++)
      get(i == n - 1, q[i]);
    stop();
  endtask
endmodule // flsr_host

// File: sim/flsr_top_monitor.sv
/*
  Pin checker of the readout block.
  Assumes it is bound into flsr_top and sees only its ports.
*/
`timescale 1ns/1ps
module flsr_top_monitor (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic smp_ready,
  input wire logic meas_en,
  input wire logic med_ipa
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_pin_low;
    sda_out == 1'b0;
  endproperty
  property p_rst_idle;
    $past(rst) |-> sda_oe_n && smp_ready && !meas_en && !med_ipa;
  endproperty
  // Data may only move while the bus clock has been low a while
  property p_edge_low;
    $changed(sda_oe_n) |-> !scl_in && !$past(scl_in, 2);
  endproperty
  property p_low_hold;
    $fell(sda_oe_n) |-> !sda_oe_n [*8];
  endproperty
  property p_rel_hold;
    $rose(sda_oe_n) |-> sda_oe_n [*8];
  endproperty
  property p_full_hold;
    !meas_en && !smp_ready |=> !smp_ready;
  endproperty
  property p_ready_rise;
    $rose(smp_ready) |-> meas_en || $past(meas_en);
  endproperty
  property p_medium;
    meas_en && $past(meas_en) |-> $stable(med_ipa);
  endproperty
  a_pin_low: assert property (p_pin_low)
    else $error("data pin output not low");
  a_rst_idle: assert property (p_rst_idle)
    else $error("outputs not idle after reset");
  a_edge_low: assert property (p_edge_low)
    else $error("data changed while bus clock high");
  a_low_hold: assert property (p_low_hold)
    else $error("low bit too short");
  a_rel_hold: assert property (p_rel_hold)
    else $error("high bit too short");
  a_full_hold: assert property (p_full_hold)
    else $error("buffer drained while idle");
  a_ready_rise: assert property (p_ready_rise)
    else $error("buffer drained outside measurement");
  a_medium: assert property (p_medium)
    else $error("medium changed while measuring");
  c_meas: cover property ($rose(meas_en));
  c_ipa: cover property (meas_en && med_ipa);
  c_drain: cover property (!smp_ready ##1 smp_ready);
endmodule // flsr_top_monitor

bind flsr_top flsr_top_monitor u_mon (.core_clk(core_clk), .rst(rst), .scl_in(scl_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .smp_ready(smp_ready), .meas_en(meas_en),
  .med_ipa(med_ipa));

// File: sim/flsr_top_bench.sv
/*
  Self-checking bench of the readout block with the host model on the bus.
  Assumes the design files and flsr_host are compiled first.
*/
`timescale 1ns/1ps
module flsr_top_bench;
  import flsr_pkg::*;
  localparam logic [6:0] ADDR = 7'h08;
  // Arbitrary value
  localparam logic [31:0] PID = 32'h1234_5601;
  // Arbitrary value
  localparam logic [63:0] SNO = 64'hFEDC_BA98_7654_3210;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic smp_valid = 1'b0;
  flsr_sample_t smp_data = '0;
  logic sda_out, sda_oe_n, smp_ready, meas_en, med_ipa, scl, sda_m, ack;
  wire logic sda_w;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  int nr [2] = '{4, 18};
  logic [7:0] q [18];
  logic [15:0] w [6];
  flsr_sample_t s [4];
  // Out of range corners per mode
  logic [15:0] fc [2][2] = '{'{16'h7FFF, 16'h810B}, '{16'h8000, 16'h7EF5}};
  assign sda_w = sda_m & (sda_oe_n | sda_out);
  always #12.5 core_clk = ~core_clk;
  flsr_top #(.DEV_ADDR(ADDR), .PROD_ID(PID), .SERIAL_NO(SNO)) i_dut (.core_clk(core_clk),
    .rst(rst), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .smp_valid(smp_valid), .smp_data(smp_data), .smp_ready(smp_ready),
    .meas_en(meas_en), .med_ipa(med_ipa));
  flsr_host i_host (.core_clk(core_clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
      finish_test();
  end
  task automatic finish_test();
    if (cyc >= 60000)
      fails++;
    if (fails == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--)
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
    return c;
  endfunction
  function automatic logic [15:0] clampf(input logic signed [15:0] f);
    return (f > 16'sh7EF4) ? 16'h7EF4 : (f < -16'sh7EF4) ? 16'h810C : f;
  endfunction
  // Whole units only, the remainder of the division is dropped
  function automatic logic [15:0] phys(input logic [15:0] v, input int sc);
    return 16'($signed(v) / sc);
  endfunction
  task automatic words(input string nm, input int n);
    for (int i = 0; i < n; i++)
    begin
      check(nm, {q[3*i], q[3*i+1]}, w[i]);
      check(nm, {8'h00, q[3*i+2]}, {8'h00, crc8(w[i])});
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    void'($urandom(40238));
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    check("idle", {13'h0000, smp_ready, meas_en, sda_oe_n}, 16'h0005);
    w = '{PID[31:16], PID[15:0], SNO[63:48], SNO[47:32], SNO[31:16], SNO[15:0]};
    i_host.cmd(ADDR, 16'h367C, ack);
    check("id cmd ack", 16'(ack), 16'h0001);
    i_host.cmd(ADDR, 16'hE102, ack);
    check("id cmd ack", 16'(ack), 16'h0001);
    foreach (nr[k])
    begin
      i_host.rd(ADDR, nr[k], ack, q);
      check("id ack", 16'(ack), 16'h0001);
      words("id", nr[k] / 3);
    end
    i_host.rd(7'h09, 3, ack, q);
    check("other addr", 16'(ack), 16'h0000);
    for (int k = 0; k < 2; k++)
    begin
      i_host.cmd(ADDR, k ? 16'hE102 : 16'h1234, ack);
      i_host.rd(ADDR, 3, ack, q);
      check("id refused", 16'(ack), 16'h0000);
    end
    for (int m = 0; m < 2; m++)
    begin
      for (int k = 0; k < 4; k++)
      begin
        s[k] = {16'($urandom), 16'($urandom), 16'($urandom)};
        if (k < 2)
          s[k].flow = fc[m][k];
        if (k == 3)
          s[k].flow = m ? 16'h7EF4 : 16'h810C;
        smp_data = s[k];
        smp_valid = 1'b1;
        @(negedge core_clk);
      end
      smp_data = 48'($urandom);
      repeat (3) @(negedge core_clk);
      check("full", 16'(smp_ready), 16'h0000);
      smp_valid = 1'b0;
      i_host.cmd(ADDR, m ? 16'h3615 : 16'h3608, ack);
      i_host.cmd(ADDR, 16'h367C, ack);
      check("busy ack", 16'(ack), 16'h0001);
      check("mode", {14'h0000, meas_en, med_ipa}, {14'h0000, 1'b1, m[0]});
      for (int k = 0; k <= 4; k++)
      begin
        i_host.rd(ADDR, 9, ack, q);
        check("set ack", 16'(ack), 16'(k < 4));
        if (k < 4)
          w = '{clampf(s[k].flow), s[k].temp, s[k].flags, 16'h0, 16'h0, 16'h0};
        words("set", (k < 4) ? 3 : 0);
        if (k < 4)
        begin
          check("flow ml", phys({q[0], q[1]}, 500), phys(w[0], 500));
          check("temp c", phys({q[3], q[4]}, 200), phys(w[1], 200));
        end
      end
      i_host.cmd(ADDR, 16'h3FF9, ack);
      check("stopped", 16'(meas_en), 16'h0000);
    end
    finish_test();
  end
endmodule // flsr_top_bench
